// file: core/nand_host_pkg.sv
// Constants and carrier types for the NAND bus host sequencer
package nand_host_pkg;
    localparam logic [7:0] cmd_read_setup   = 8'h00;
    localparam logic [7:0] cmd_read_confirm = 8'h30;
    localparam logic [7:0] cmd_copy_confirm = 8'h35;
    localparam logic [7:0] cmd_rnd_out      = 8'h05;
    localparam logic [7:0] cmd_rnd_out_conf = 8'he0;
    localparam logic [7:0] cmd_prog_setup   = 8'h80;
    localparam logic [7:0] cmd_rnd_in       = 8'h85;
    localparam logic [7:0] cmd_prog_confirm = 8'h10;
    localparam logic [7:0] cmd_erase_setup  = 8'h60;
    localparam logic [7:0] cmd_erase_conf   = 8'hd0;
    localparam logic [7:0] cmd_status       = 8'h70;
    localparam logic [7:0] cmd_reset        = 8'hff;
    localparam int         status_rdy_bit   = 6;
    localparam int         status_fail_bit  = 0;
    localparam int         page_bytes       = 2112;
    localparam int         full_addr_cycles = 5;
    localparam int         blk_addr_cycles  = 3;
    localparam int         addr_bits        = 29;
    localparam int         col_bits         = 12;
    localparam int         page_load_time_ns = 25000;
    localparam int         clk_period_ns    = 10;
    localparam int         page_load_cycles =
        (page_load_time_ns + clk_period_ns - 1) / clk_period_ns;
    // Strobe phases: low half and high half of each bus cycle
    localparam logic [2:0] strobe_half      = 3'h2;
    localparam logic [2:0] strobe_len_w     = 3'h3;

    // Operation kinds requested by the user side
    typedef enum logic [3:0] {
        op_read      = 4'h0,
        op_program   = 4'h1,
        op_erase     = 4'h2,
        op_copy_read = 4'h3,
        op_copy_prog = 4'h4,
        op_rnd_out   = 4'h5,
        op_status    = 4'h6,
        op_reset     = 4'h7
    } op_type;

    typedef struct packed {
        op_type      op;
        logic [28:0] addr;   // A29..A1 packed as row[16:0], col[11:0]
        logic [11:0] count;  // data bytes to move
    } req_type;

    typedef struct packed {
        logic       done;
        logic       fail;
        logic [7:0] status;
    } rsp_type;
endpackage

// file: core/nand_bus_and_operation_sequencer.sv
// Host sequencer that drives a large-page NAND device over its pins
// How it works
// - Command byte on rising write strobe
// - Hold write protect high for program/erase
// - Five address cycles (three for erase, two for random out), address latch high
// - Program bytes one per write strobe
// - Read bytes one per read strobe
// - Page read: 00h, address, 30h
// - Partial programs limited per segment (not enforced: no count of programs is kept)
// - Program pages in ascending order (not enforced: each row is sent as requested)
// - Program load: 80h, address, data
// - Erase: 60h, three row cycles, D0h
// - Copy-back: 85h, address, data, 10h
// - Copy pages share plane and parity (not checked: source and target rows are sent as requested)
`timescale 1ns/100ps
`default_nettype none
module nand_bus_and_operation_sequencer (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    // Request side
    input  wire nand_host_pkg::req_type req,
    input  wire logic                  req_valid,
    output logic                       req_ready,
    output nand_host_pkg::rsp_type     rsp,
    // Write data stream into the device
    input  wire logic [7:0]            wr_data,
    input  wire logic                  wr_valid,
    output logic                       wr_ready,
    // Read data stream out of the device
    output logic [7:0]                 rd_data,
    output logic                       rd_valid,
    input  wire logic                  rd_ready,
    // NAND pins
    output logic                       chip_sel_n,
    output logic                       cmd_latch,
    output logic                       addr_latch,
    output logic                       write_strobe_n,
    output logic                       read_strobe_n,
    output logic                       write_prot_n,
    output logic [7:0]                 io_bus_out,
    output logic                       io_bus_oe,
    input  wire logic [7:0]            io_bus_in,
    input  wire logic                  ready_busy
);
    typedef enum logic [7:0] {
        st_idle  = 8'h01,
        st_cmd1  = 8'h02,
        st_addr  = 8'h04,
        st_cmd2  = 8'h08,
        st_wait  = 8'h10,
        st_data  = 8'h20,
        st_poll  = 8'h40,
        st_fin   = 8'h80
    } state_type;
    state_type                state_ff, nxt_state;
    nand_host_pkg::req_type   req_ff;
    logic [2:0]               ph_ff, acnt_ff;
    logic [11:0]              dcnt_ff;
    logic [14:0]              wcnt_ff;
    logic                     rb_meta_ff, rb_ff;
    logic [7:0]               io_meta_ff, io_ff, byte_ff, rsp_stat_ff;
    logic                     rsp_done_ff, rsp_fail_ff, stat_ff;
    // Two-entry read buffer
    logic [7:0]               buf_ff [2];
    logic                     wp_ff, rp_ff;
    logic [1:0]               cnt_ff;
    // Pins pass two flops before use
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rb_meta_ff <= 1'b0;
            rb_ff      <= 1'b0;
            io_meta_ff <= 8'h00;
            io_ff      <= 8'h00;
        end else begin
            rb_meta_ff <= ready_busy;
            rb_ff      <= rb_meta_ff;
            io_meta_ff <= io_bus_in;
            io_ff      <= io_meta_ff;
        end
    end
    function automatic logic [7:0] addr_byte(
        input logic [28:0] a, input logic [2:0] i);
        logic [7:0] r;
        case (i)
            3'h0: r = a[7:0];
            3'h1: r = {4'h0, a[11:8]};
            3'h2: r = a[19:12];
            3'h3: r = a[27:20];
            default: r = {7'h00, a[28]};
        endcase
        return r;
    endfunction
    wire nand_host_pkg::op_type op = req_ff.op;
    wire is_erase   = (op == nand_host_pkg::op_erase);
    wire is_prog    = (op == nand_host_pkg::op_program) ||
                      (op == nand_host_pkg::op_copy_prog);
    wire is_read    = (op == nand_host_pkg::op_read) ||
                      (op == nand_host_pkg::op_rnd_out);
    wire one_cmd    = (op == nand_host_pkg::op_status) ||
                      (op == nand_host_pkg::op_reset);
    wire col_only   = (op == nand_host_pkg::op_rnd_out);
    // Erase skips the two column cycles
    wire [2:0] a_first = is_erase ? 3'h2 : 3'h0;
    wire [2:0] a_last  = col_only ? 3'h1 : 3'h4;
    wire [7:0] cmd1 =
        is_erase ? nand_host_pkg::cmd_erase_setup :
        (op == nand_host_pkg::op_program) ? nand_host_pkg::cmd_prog_setup :
        (op == nand_host_pkg::op_copy_prog) ? nand_host_pkg::cmd_rnd_in :
        col_only ? nand_host_pkg::cmd_rnd_out :
        (op == nand_host_pkg::op_status) ? nand_host_pkg::cmd_status :
        (op == nand_host_pkg::op_reset) ? nand_host_pkg::cmd_reset :
        nand_host_pkg::cmd_read_setup;
    wire [7:0] cmd2 =
        stat_ff ? nand_host_pkg::cmd_status :
        is_erase ? nand_host_pkg::cmd_erase_conf :
        is_prog ? nand_host_pkg::cmd_prog_confirm :
        col_only ? nand_host_pkg::cmd_rnd_out_conf :
        (op == nand_host_pkg::op_copy_read) ?
            nand_host_pkg::cmd_copy_confirm :
        nand_host_pkg::cmd_read_confirm;
    wire ph_end   = (ph_ff == nand_host_pkg::strobe_len_w);
    wire ph_low   = (ph_ff < nand_host_pkg::strobe_half);
    wire buf_full = (cnt_ff == 2'h2);
    wire data_go  = is_prog ? wr_valid : !buf_full;
    wire in_data  = (state_ff == st_data);
    wire in_addr  = (state_ff == st_addr);
    wire in_cmd   = (state_ff == st_cmd1) || (state_ff == st_cmd2);
    wire wait_ok  = rb_ff && (wcnt_ff == 15'h0000);
    wire cycle_on = in_cmd || in_addr || (in_data && (ph_ff != 3'h0 ||
                    data_go));
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            st_idle: if (req_valid) nxt_state = st_cmd1;
            st_cmd1: if (ph_end)
                nxt_state = one_cmd ? (op == nand_host_pkg::op_reset ?
                    st_wait : st_poll) : st_addr;
            st_addr: if (ph_end && acnt_ff == a_last)
                nxt_state = (is_prog && req_ff.count != 12'h000) ?
                    st_data : (op == nand_host_pkg::op_program ?
                    st_fin : st_cmd2);
            st_cmd2: if (ph_end)
                nxt_state = stat_ff ? st_poll : (col_only ? st_data : st_wait);
            st_wait: if (wait_ok)
                nxt_state = (is_read && req_ff.count != 12'h000) ?
                    st_data : (op == nand_host_pkg::op_reset) ?
                    st_fin : st_cmd2;
            st_data: if (ph_end && dcnt_ff == 12'h001)
                nxt_state = is_prog ? st_cmd2 : st_fin;
            st_poll: if (ph_end) nxt_state = st_fin;
            st_fin:  nxt_state = st_idle;
            default: nxt_state = st_idle;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= st_idle;
            req_ff   <= '0;
            ph_ff    <= 3'h0;
            acnt_ff  <= 3'h0;
            dcnt_ff  <= 12'h000;
            wcnt_ff  <= 15'h0000;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == st_idle && req_valid) req_ff <= req;
            ph_ff <= (state_ff != nxt_state || ph_end || !cycle_on &&
                      state_ff != st_poll) ? 3'h0 : ph_ff + 3'h1;
            if (state_ff == st_cmd1)
                acnt_ff <= a_first;
            else if (in_addr && ph_end)
                acnt_ff <= acnt_ff + 3'h1;
            if (state_ff == st_idle)
                dcnt_ff <= req.count;
            else if (in_data && ph_end)
                dcnt_ff <= dcnt_ff - 12'h001;
            // Busy may not show for a few cycles, so wait the minimum
            if (state_ff == st_cmd2 || state_ff == st_cmd1)
                wcnt_ff <= 15'(nand_host_pkg::strobe_len_w) + 15'h0004;
            else if (wcnt_ff != 15'h0000)
                wcnt_ff <= wcnt_ff - 15'h0001;
        end
    end

    // Pin drive
    wire wr_cycle = in_cmd || in_addr || (in_data && is_prog);
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            byte_ff <= 8'h00;
        end else if (state_ff == st_cmd1) begin
            byte_ff <= cmd1;
        end else if (state_ff == st_cmd2) begin
            byte_ff <= cmd2;
        end else if (in_addr) begin
            byte_ff <= addr_byte(req_ff.addr, acnt_ff);
        end else if (in_data && is_prog && ph_ff == 3'h0) begin
            byte_ff <= wr_data;
        end
    end
    assign io_bus_out     = in_cmd ? ((state_ff == st_cmd1) ? cmd1 : cmd2)
                          : byte_ff;
    assign io_bus_oe      = wr_cycle;
    assign chip_sel_n     = (state_ff == st_idle) || (state_ff == st_fin);
    assign cmd_latch      = in_cmd;
    assign addr_latch     = in_addr;
    assign write_strobe_n = !(wr_cycle && cycle_on && ph_low);
    assign read_strobe_n  = !(((in_data && !is_prog && cycle_on) ||
                              state_ff == st_poll) && ph_low);
    // Protect released only while a program or erase is selected
    assign write_prot_n   = (is_prog || is_erase) && !chip_sel_n;
    assign wr_ready       = in_data && is_prog && ph_ff == 3'h0;
    assign req_ready      = (state_ff == st_idle);

    wire cap_rd = in_data && !is_prog && ph_ff == nand_host_pkg::strobe_half;
    wire cap_st = (state_ff == st_poll) && ph_end;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rsp_done_ff <= 1'b0;
            rsp_fail_ff <= 1'b0;
            rsp_stat_ff <= 8'h00;
            stat_ff     <= 1'b0;
        end else begin
            rsp_done_ff <= (state_ff == st_fin);
            stat_ff     <= (state_ff == st_wait) ? wait_ok :
                           stat_ff && (state_ff != st_fin);
            if (cap_st) begin
                rsp_stat_ff <= io_ff;
                rsp_fail_ff <= io_ff[nand_host_pkg::status_fail_bit];
            end
        end
    end
    assign rsp = '{done: rsp_done_ff, fail: rsp_fail_ff,
                   status: rsp_stat_ff};

    // Read buffer: strobe pauses while both entries are held
    wire push = cap_rd;
    wire pop  = rd_valid && rd_ready;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wp_ff  <= 1'b0;
            rp_ff  <= 1'b0;
            cnt_ff <= 2'h0;
        end else begin
            if (push) wp_ff <= !wp_ff;
            if (pop)  rp_ff <= !rp_ff;
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end
    always_ff @(posedge ref_clk) begin
        if (push) buf_ff[wp_ff] <= io_ff;
    end
    assign rd_data  = buf_ff[rp_ff];
    assign rd_valid = (cnt_ff != 2'h0);

    // Checks
    sequence cmd_strobe_s;
        cmd_latch && !addr_latch && !chip_sel_n && read_strobe_n;
    endsequence
    cmd_strobe_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        !write_strobe_n && cmd_latch |-> cmd_strobe_s)
        else $error("command strobe with wrong latch levels");
    addr_strobe_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        !write_strobe_n && addr_latch |-> !cmd_latch && read_strobe_n)
        else $error("address strobe with wrong levels");
    data_strobe_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        in_data && !write_strobe_n |-> write_prot_n && read_strobe_n)
        else $error("data strobe with protect low");
    rd_strobe_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        !read_strobe_n |-> write_strobe_n && !cmd_latch && !addr_latch)
        else $error("read strobe with wrong levels");
    erase_prot_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        in_cmd && is_erase |-> write_prot_n)
        else $error("erase issued while protected");
    wait_ready_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        state_ff == st_wait && nxt_state == st_data |-> rb_ff)
        else $error("output started while busy");
    no_overflow_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        buf_full |-> !push)
        else $error("read buffer overflow");
    fin_done_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        state_ff == st_fin |=> rsp.done ##1 !rsp.done)
        else $error("done not a single pulse");
endmodule
`default_nettype wire

// file: verification/nand_device_model.sv
// Behavioural model of the NAND array device on the far side of the host
`timescale 1ns/100ps
`default_nettype none
module nand_device_model #(
    parameter int load_ns = 25000,
    parameter int busy_ns = 4000
) (
    // Control pins from the host
    input  wire logic       chip_sel_n,
    input  wire logic       cmd_latch,
    input  wire logic       addr_latch,
    input  wire logic       write_strobe_n,
    input  wire logic       read_strobe_n,
    input  wire logic       write_prot_n,
    // Data bus and open-drain busy pull-down
    input  wire logic [7:0] io_bus,
    output logic      [7:0] dev_data,
    output logic            rb_low
);
    logic [7:0] preg  [nand_host_pkg::page_bytes];
    logic       wmask [nand_host_pkg::page_bytes];
    logic [7:0] mem   [int];
    logic [7:0] abyte [5] = '{default: 8'h00};
    int         acnt = 5;
    int         col = 0;
    int         row = 0;
    int         nload = 0;
    int         left_ns = 0;
    logic       stat_mode = 1'b0;
    logic       fail = 1'b0;
    logic       copy_ok = 1'b0;

    initial dev_data = 8'h5a;
    assign rb_low = (left_ns > 0);
    // Timer ignores chip select, so deselecting never aborts a load
    always #10 if (left_ns > 0) left_ns = left_ns - 10;

    task automatic command(input logic [7:0] c);
        if (left_ns > 0 && c != 8'h70 && c != 8'hff) return;
        stat_mode = (c == 8'h70);
        case (c)
            8'h00, 8'h05: acnt = 0;
            8'h80: begin
                acnt = 0;
                nload = 0;
                copy_ok = 1'b0;
                foreach (preg[i]) begin
                    preg[i] = 8'hff;
                    wmask[i] = 1'b0;
                end
            end
            8'h85: begin
                acnt = 0;
                if (copy_ok) foreach (wmask[i]) wmask[i] = 1'b1;
                if (copy_ok) nload = nand_host_pkg::page_bytes;
            end
            8'h30, 8'h35: begin
                foreach (preg[i])
                    preg[i] = mem.exists(row * 4096 + i) ? mem[row * 4096 + i]
                                                          : 8'hff;
                copy_ok = (c == 8'h35);
                left_ns = load_ns;
            end
            8'h10: if (write_prot_n && nload > 0) begin
                foreach (preg[i]) if (wmask[i]) mem[row * 4096 + i] = preg[i];
                fail = 1'b0;
                left_ns = busy_ns;
            end
            8'h60: acnt = 2;
            8'hd0: if (write_prot_n) begin
                for (int p = 0; p < 64; p++)
                    for (int i = 0; i < nand_host_pkg::page_bytes; i++)
                        mem.delete(((row & ~63) + p) * 4096 + i);
                fail = 1'b0;
                left_ns = busy_ns;
            end
            8'hff: begin
                acnt = 5;
                fail = 1'b0;
                left_ns = 500;
            end
            default: ;
        endcase
    endtask

    always @(posedge write_strobe_n) if (!chip_sel_n && read_strobe_n) begin
        if (cmd_latch && !addr_latch) command(io_bus);
        else if (addr_latch && !cmd_latch && acnt < 5) begin
            abyte[acnt] = io_bus;
            acnt++;
            col = {abyte[1][3:0], abyte[0]};
            row = {abyte[4][0], abyte[3], abyte[2]};
        end else if (!cmd_latch && !addr_latch && write_prot_n
                     && col < nand_host_pkg::page_bytes) begin
            preg[col] = io_bus;
            wmask[col] = 1'b1;
            nload++;
            col++;
        end
    end

    always @(negedge read_strobe_n)
        if (!chip_sel_n && write_strobe_n && !cmd_latch && !addr_latch) begin
            #8;
            dev_data = stat_mode ? {write_prot_n, !rb_low, !rb_low, 4'h0, fail}
                                 : preg[col];
            if (!stat_mode && col < nand_host_pkg::page_bytes - 1) col++;
        end
    // Released bus shows the inverse, never a stale byte
    always @(posedge read_strobe_n) begin
        #15;
        dev_data = ~dev_data;
    end
endmodule
`default_nettype wire

// file: verification/tb_nand_bus_and_operation_sequencer.sv
// Testbench for the NAND host sequencer against the device model
`timescale 1ns/100ps
`default_nettype none
module tb_nand_bus_and_operation_sequencer;
    logic                   ref_clk = 1'b0;
    logic                   resetn = 1'b0;
    nand_host_pkg::req_type req = '0;
    nand_host_pkg::rsp_type rsp;
    logic                   req_valid = 1'b0;
    logic                   req_ready, wr_ready, rd_valid, rd_ready = 1'b0;
    logic                   wr_valid = 1'b0;
    logic                   wr_take = 1'b0;
    logic [7:0]             wr_data = 8'h00;
    logic [7:0]             rd_data, io_bus_out, io_bus_in, dev_data;
    logic                   chip_sel_n, cmd_latch, addr_latch, write_prot_n;
    logic                   write_strobe_n, read_strobe_n, io_bus_oe, rb_low;
    int                     err_total = 0;
    int                     check_count = 0;
    int                     tick = 0;
    logic [7:0]             wq[$];
    logic [7:0]             rq[$];
    localparam logic [16:0] row_a = 17'h00042;
    localparam logic [16:0] row_b = 17'h00084;

    always #5 ref_clk = ~ref_clk;
    assign io_bus_in = io_bus_oe ? io_bus_out : dev_data;

    nand_bus_and_operation_sequencer nand_bus_and_operation_sequencer_inst (
        .ref_clk(ref_clk), .resetn(resetn), .req(req), .req_valid(req_valid),
        .req_ready(req_ready), .rsp(rsp), .wr_data(wr_data),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .chip_sel_n(chip_sel_n),
        .cmd_latch(cmd_latch), .addr_latch(addr_latch),
        .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
        .write_prot_n(write_prot_n), .io_bus_out(io_bus_out),
        .io_bus_oe(io_bus_oe), .io_bus_in(io_bus_in), .ready_busy(~rb_low));

    nand_device_model #(.load_ns(3000), .busy_ns(4000)) nand_device_model_inst (
        .chip_sel_n(chip_sel_n), .cmd_latch(cmd_latch),
        .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
        .read_strobe_n(read_strobe_n), .write_prot_n(write_prot_n),
        .io_bus(io_bus_in), .dev_data(dev_data), .rb_low(rb_low));

    // Long reader stalls keep the two-entry buffer full
    always @(negedge ref_clk) begin
        tick++;
        if (wr_take) void'(wq.pop_front());
        wr_valid = (wq.size() > 0);
        wr_data = wr_valid ? wq[0] : 8'h00;
        rd_ready = (tick % 16) < 3;
        #1;
        wr_take = wr_valid && wr_ready;
        if (rd_valid === 1'b1 && rd_ready) rq.push_back(rd_data);
    end

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_read(input logic [7:0] exp[$]);
        check("read count", 8'(exp.size()), 8'(rq.size()));
        foreach (exp[i]) check("read byte", exp[i],
                               i < rq.size() ? rq[i] : 8'hxx);
        rq.delete();
    endtask

    task automatic run_op(input nand_host_pkg::op_type o,
                          input logic [28:0] a, input logic [11:0] n);
        int w;
        @(negedge ref_clk);
        req.op = o;
        req.addr = a;
        req.count = n;
        req_valid = 1'b1;
        w = 0;
        while (req_ready !== 1'b1 && w < 100) begin
            @(negedge ref_clk);
            w++;
        end
        @(negedge ref_clk);
        req_valid = 1'b0;
        w = 0;
        while (rsp.done !== 1'b1 && w < 20000) begin
            @(negedge ref_clk);
            w++;
        end
        check("operation done", 8'h01, {7'h0, rsp.done});
        repeat (64) @(negedge ref_clk);
    endtask

    task automatic t_program;
        wq = '{8'h11, 8'h22, 8'h33, 8'h44};
        run_op(nand_host_pkg::op_program, {row_a, 12'h000}, 12'h004);
        for (int i = 0; i < 4; i++)
            check("array byte", 8'(8'h11 * (i + 1)),
                  nand_device_model_inst.mem[row_a * 4096 + i]);
        check("program fail", 8'h00, {7'h0, rsp.fail});
        check("program ready", 8'h40, rsp.status & 8'h40);
        check("protect idle", 8'h00, {7'h0, write_prot_n});
        $display("Test program finished");
    endtask

    task automatic t_read;
        run_op(nand_host_pkg::op_read, {row_a, 12'h001}, 12'h003);
        check_read('{8'h22, 8'h33, 8'h44});
        run_op(nand_host_pkg::op_rnd_out, {row_a, 12'h000}, 12'h002);
        check_read('{8'h11, 8'h22});
        $display("Test read finished");
    endtask

    task automatic t_copy;
        run_op(nand_host_pkg::op_copy_read, {row_a, 12'h000}, 12'h000);
        wq = '{8'h5c};
        run_op(nand_host_pkg::op_copy_prog, {row_b, 12'h003}, 12'h001);
        run_op(nand_host_pkg::op_read, {row_b, 12'h000}, 12'h004);
        check_read('{8'h11, 8'h22, 8'h33, 8'h5c});
        $display("Test copy finished");
    endtask

    task automatic t_erase;
        run_op(nand_host_pkg::op_erase, {row_a, 12'h000}, 12'h000);
        run_op(nand_host_pkg::op_read, {row_a, 12'h000}, 12'h002);
        check_read('{8'hff, 8'hff});
        run_op(nand_host_pkg::op_reset, 29'h0, 12'h000);
        run_op(nand_host_pkg::op_status, 29'h0, 12'h000);
        check("status ready", 8'h40, rsp.status & 8'h41);
        $display("Test erase and status finished");
    endtask

    task automatic print_verdict;
        $display("Checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #500000;
        err_total++;
        $display("MISMATCH watchdog expected finish seen timeout");
        print_verdict();
    end

    initial begin
        repeat (16) @(negedge ref_clk);
        resetn = 1'b1;
        t_program();
        t_read();
        t_copy();
        t_erase();
        print_verdict();
    end
endmodule
`default_nettype wire
